// >>> include/icl_pkg.sv
// Shared constants, types and address decoding for the inter-core link.
package icl_pkg;

	localparam int ADDR_W     = 14;
	localparam int RAM_DEPTH  = 1024;
	localparam int RAM_WIDTH  = 16;
	localparam int EVT_W      = 32;
	localparam int IRQ_EVT_W  = 4;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	// Byte offsets inside each core's window.
	localparam logic [13:0] TX_RAM_BASE  = 14'h0000;
	localparam logic [13:0] RX_RAM_BASE  = 14'h1000;
	localparam logic [13:0] EVT_SET_OFS  = 14'h2000;
	localparam logic [13:0] EVT_FLG_OFS  = 14'h2004;
	localparam logic [13:0] EVT_ACK_OFS  = 14'h2008;
	localparam logic [13:0] IRQ_STS_OFS  = 14'h200c;
	localparam logic [13:0] IRQ_MSK_OFS  = 14'h2010;
	localparam logic [13:0] TX_CMD0_OFS  = 14'h2014;
	localparam logic [13:0] TX_CMD1_OFS  = 14'h2018;
	localparam logic [13:0] TX_CMD2_OFS  = 14'h201c;
	localparam logic [13:0] TX_REPL_OFS  = 14'h2020;
	localparam logic [13:0] RX_CMD0_OFS  = 14'h2024;
	localparam logic [13:0] RX_CMD1_OFS  = 14'h2028;
	localparam logic [13:0] RX_CMD2_OFS  = 14'h202c;
	localparam logic [13:0] RX_REPL_OFS  = 14'h2030;

	localparam logic [31:0] EVT_RST  = 32'h0000_0000;
	localparam logic [3:0]  IRQ_RST  = 4'h0;
	localparam logic [31:0] CMD_RST  = 32'h0000_0000;
	localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WR    = 2'b01,
		ST_RD    = 2'b10,
		ST_RDONE = 2'b11
	} icl_port_state_t;

	typedef enum logic [3:0] {
		SEL_NONE    = 4'b0000,
		SEL_TXRAM   = 4'b0001,
		SEL_RXRAM   = 4'b0010,
		SEL_EVT_SET = 4'b0011,
		SEL_EVT_FLG = 4'b0100,
		SEL_EVT_ACK = 4'b0101,
		SEL_IRQ_STS = 4'b0110,
		SEL_IRQ_MSK = 4'b0111,
		SEL_TX_CMD0 = 4'b1000,
		SEL_TX_CMD1 = 4'b1001,
		SEL_TX_CMD2 = 4'b1010,
		SEL_TX_REPL = 4'b1011,
		SEL_RX_CMD0 = 4'b1100,
		SEL_RX_CMD1 = 4'b1101,
		SEL_RX_CMD2 = 4'b1110,
		SEL_RX_REPL = 4'b1111
	} icl_sel_t;

	// Maps a word-aligned byte address onto the resource it selects.
	function automatic icl_sel_t icl_decode(input logic [13:0] a);
		icl_sel_t s;
		s = SEL_NONE;
		if (a[13:12] == TX_RAM_BASE[13:12]) begin
			s = SEL_TXRAM;
		end else if (a[13:12] == RX_RAM_BASE[13:12]) begin
			s = SEL_RXRAM;
		end else begin
			case (a)
				EVT_SET_OFS: s = SEL_EVT_SET;
				EVT_FLG_OFS: s = SEL_EVT_FLG;
				EVT_ACK_OFS: s = SEL_EVT_ACK;
				IRQ_STS_OFS: s = SEL_IRQ_STS;
				IRQ_MSK_OFS: s = SEL_IRQ_MSK;
				TX_CMD0_OFS: s = SEL_TX_CMD0;
				TX_CMD1_OFS: s = SEL_TX_CMD1;
				TX_CMD2_OFS: s = SEL_TX_CMD2;
				TX_REPL_OFS: s = SEL_TX_REPL;
				RX_CMD0_OFS: s = SEL_RX_CMD0;
				RX_CMD1_OFS: s = SEL_RX_CMD1;
				RX_CMD2_OFS: s = SEL_RX_CMD2;
				RX_REPL_OFS: s = SEL_RX_REPL;
				default:     s = SEL_NONE;
			endcase
		end
		return s;
	endfunction

	// Sticky flag update in which a set in the same cycle beats a clear.
	function automatic logic [31:0] icl_flag_next(input logic [31:0] cur, input logic [31:0] set,
		input logic [31:0] clr);
		return (cur & ~clr) | set;
	endfunction

endpackage

// >>> src/icl_msg_ram.sv
// One-way message memory: written from one core, read from the other.
`timescale 1ns/10ps
module icl_msg_ram #(
	parameter int DEPTH = icl_pkg::RAM_DEPTH,
	parameter int WIDTH = icl_pkg::RAM_WIDTH,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             clock,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [0:DEPTH-1];

	// The read port has no write path, which fixes the direction of travel.
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];

endmodule // icl_msg_ram

// >>> src/icl_ahb_port.sv
// AHB-Lite slave front end: zero-wait writes, one-wait reads, always OKAY.
`timescale 1ns/10ps
module icl_ahb_port #(
	parameter int AW = icl_pkg::ADDR_W
) (
	input  wire logic          clock,
	input  wire logic          rst_b,
	input  wire logic          hsel,
	input  wire logic [AW-1:0] haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic [31:0]        hrdata,
	output logic               hresp,
	output logic [AW-1:0]      acc_addr,
	output logic               acc_wr,
	output logic [31:0]        acc_wdata,
	input  wire logic [31:0]   acc_rdata
);

	icl_pkg::icl_port_state_t state;
	icl_pkg::icl_port_state_t next_state;
	logic [AW-3:0]            widx;
	logic [AW-3:0]            next_widx;
	logic                     next_hreadyout;
	logic [31:0]              next_hrdata;
	logic                     take;

	// Only whole-word singles are issued, so hsize carries no information here.
	assign take = hsel & htrans[1] & hready;

	always_comb begin
		next_state     = icl_pkg::ST_IDLE;
		next_widx      = widx;
		next_hrdata    = hrdata;
		next_hreadyout = 1'b1;
		case (state)
			icl_pkg::ST_RD: begin
				next_state  = icl_pkg::ST_RDONE;
				next_hrdata = acc_rdata;
			end
			icl_pkg::ST_IDLE, icl_pkg::ST_WR, icl_pkg::ST_RDONE: begin
				if (take) begin
					next_widx = haddr[AW-1:2];
					if (hwrite) begin
						next_state = icl_pkg::ST_WR;
					end else begin
						next_state     = icl_pkg::ST_RD;
						next_hreadyout = 1'b0;
					end
				end
			end
			default: next_state = icl_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state     <= icl_pkg::ST_IDLE;
			widx      <= '0;
			hrdata    <= icl_pkg::RD_ZERO;
			hreadyout <= 1'b1;
		end else begin
			state     <= next_state;
			widx      <= next_widx;
			hrdata    <= next_hrdata;
			hreadyout <= next_hreadyout;
		end
	end

	assign hresp     = icl_pkg::HRESP_OKAY;
	assign acc_addr  = {widx, 2'b00};
	assign acc_wr    = (state == icl_pkg::ST_WR);
	assign acc_wdata = hwdata;

endmodule // icl_ahb_port

// >>> src/icl_top.sv
// Inter-core link: message memories, event flags, interrupts and command registers.
`timescale 1ns/10ps

module icl_top (
	input  wire logic                         clock,
	input  wire logic                         rst_b,
	input  wire logic                         c1_hsel,
	input  wire logic [icl_pkg::ADDR_W-1:0]   c1_haddr,
	input  wire logic [1:0]                   c1_htrans,
	input  wire logic                         c1_hwrite,
	input  wire logic [2:0]                   c1_hsize,
	input  wire logic [31:0]                  c1_hwdata,
	input  wire logic                         c1_hready,
	output logic                              c1_hreadyout,
	output logic [31:0]                       c1_hrdata,
	output logic                              c1_hresp,
	output logic                              c1_irq,
	input  wire logic                         c2_hsel,
	input  wire logic [icl_pkg::ADDR_W-1:0]   c2_haddr,
	input  wire logic [1:0]                   c2_htrans,
	input  wire logic                         c2_hwrite,
	input  wire logic [2:0]                   c2_hsize,
	input  wire logic [31:0]                  c2_hwdata,
	input  wire logic                         c2_hready,
	output logic                              c2_hreadyout,
	output logic [31:0]                       c2_hrdata,
	output logic                              c2_hresp,
	output logic                              c2_irq
);

	// Word address width of one message memory.
	localparam int RAW = $clog2(icl_pkg::RAM_DEPTH);

	logic [icl_pkg::ADDR_W-1:0]   c1_addr;
	logic [icl_pkg::ADDR_W-1:0]   c2_addr;
	logic                         c1_wr;
	logic                         c2_wr;
	logic [31:0]                  c1_wdata;
	logic [31:0]                  c2_wdata;
	logic [31:0]                  c1_rdata;
	logic [31:0]                  c2_rdata;
	icl_pkg::icl_sel_t            c1_sel;
	icl_pkg::icl_sel_t            c2_sel;
	logic [icl_pkg::RAM_WIDTH-1:0] ram12_q;
	logic [icl_pkg::RAM_WIDTH-1:0] ram21_q;
	logic                          ram12_we;
	logic                          ram21_we;

	// Event flags: evt12 travels from the first core, evt21 from the second.
	logic [31:0] evt12;
	logic [31:0] evt21;
	logic [31:0] next_evt12;
	logic [31:0] next_evt21;

	// Decoded write strobes, one bit per flag, shared by flags and interrupts.
	logic [31:0] set12;
	logic [31:0] set21;
	logic [31:0] ack12;
	logic [31:0] ack21;
	logic [31:0] clr1;
	logic [31:0] clr2;
	logic [31:0] sts1_w;
	logic [31:0] sts2_w;

	// Interrupt status and masks, indexed by the receiving core.
	logic [3:0]  sts1;
	logic [3:0]  sts2;
	logic [3:0]  msk1;
	logic [3:0]  msk2;
	logic [3:0]  next_sts1;
	logic [3:0]  next_sts2;
	logic [3:0]  next_msk1;
	logic [3:0]  next_msk2;
	logic        next_c1_irq;
	logic        next_c2_irq;

	// Command sets: cmdXY written by core X, repXY written by core Y in answer.
	logic [31:0] cmd12 [0:2];
	logic [31:0] cmd21 [0:2];
	logic [31:0] rep12;
	logic [31:0] rep21;
	logic [31:0] next_cmd12 [0:2];
	logic [31:0] next_cmd21 [0:2];
	logic [31:0] next_rep12;
	logic [31:0] next_rep21;

	// Each core reaches the block through a bus port of its own.
	icl_ahb_port #(
		.AW (icl_pkg::ADDR_W)
	) u_port1 (
		.clock     (clock),
		.rst_b     (rst_b),
		.hsel      (c1_hsel),
		.haddr     (c1_haddr),
		.htrans    (c1_htrans),
		.hwrite    (c1_hwrite),
		.hsize     (c1_hsize),
		.hwdata    (c1_hwdata),
		.hready    (c1_hready),
		.hreadyout (c1_hreadyout),
		.hrdata    (c1_hrdata),
		.hresp     (c1_hresp),
		.acc_addr  (c1_addr),
		.acc_wr    (c1_wr),
		.acc_wdata (c1_wdata),
		.acc_rdata (c1_rdata)
	);

	icl_ahb_port #(
		.AW (icl_pkg::ADDR_W)
	) u_port2 (
		.clock     (clock),
		.rst_b     (rst_b),
		.hsel      (c2_hsel),
		.haddr     (c2_haddr),
		.htrans    (c2_htrans),
		.hwrite    (c2_hwrite),
		.hsize     (c2_hsize),
		.hwdata    (c2_hwdata),
		.hready    (c2_hready),
		.hreadyout (c2_hreadyout),
		.hrdata    (c2_hrdata),
		.hresp     (c2_hresp),
		.acc_addr  (c2_addr),
		.acc_wr    (c2_wr),
		.acc_wdata (c2_wdata),
		.acc_rdata (c2_rdata)
	);

	assign c1_sel = icl_pkg::icl_decode(c1_addr);
	assign c2_sel = icl_pkg::icl_decode(c2_addr);
	assign ram12_we = c1_wr && (c1_sel == icl_pkg::SEL_TXRAM);
	assign ram21_we = c2_wr && (c2_sel == icl_pkg::SEL_TXRAM);

	// First core writes, second core reads.
	icl_msg_ram #(
		.DEPTH (icl_pkg::RAM_DEPTH),
		.WIDTH (icl_pkg::RAM_WIDTH)
	) u_ram12 (
		.clock   (clock),
		.wr_en   (ram12_we),
		.wr_addr (c1_addr[RAW+1:2]),
		.wr_data (c1_wdata[icl_pkg::RAM_WIDTH-1:0]),
		.rd_addr (c2_addr[RAW+1:2]),
		.rd_data (ram12_q)
	);

	// Second core writes, first core reads.
	icl_msg_ram #(
		.DEPTH (icl_pkg::RAM_DEPTH),
		.WIDTH (icl_pkg::RAM_WIDTH)
	) u_ram21 (
		.clock   (clock),
		.wr_en   (ram21_we),
		.wr_addr (c2_addr[RAW+1:2]),
		.wr_data (c2_wdata[icl_pkg::RAM_WIDTH-1:0]),
		.rd_addr (c1_addr[RAW+1:2]),
		.rd_data (ram21_q)
	);

	// Write strobes decoded once, so flags and interrupts see the same access.
	always_comb begin
		set12 = (c1_wr && (c1_sel == icl_pkg::SEL_EVT_SET)) ? c1_wdata : 32'h0000_0000;
		set21 = (c2_wr && (c2_sel == icl_pkg::SEL_EVT_SET)) ? c2_wdata : 32'h0000_0000;
		ack12 = (c2_wr && (c2_sel == icl_pkg::SEL_EVT_ACK)) ? c2_wdata : 32'h0000_0000;
		ack21 = (c1_wr && (c1_sel == icl_pkg::SEL_EVT_ACK)) ? c1_wdata : 32'h0000_0000;
		clr1  = (c1_wr && (c1_sel == icl_pkg::SEL_IRQ_STS)) ? c1_wdata : 32'h0000_0000;
		clr2  = (c2_wr && (c2_sel == icl_pkg::SEL_IRQ_STS)) ? c2_wdata : 32'h0000_0000;
	end

	// Event flags: the sender sets with ones, the receiver clears with ones.
	// A flag set and acknowledged in the same cycle stays set, so no event is lost.
	always_comb begin
		next_evt12 = icl_pkg::icl_flag_next(evt12, set12, ack12);
		next_evt21 = icl_pkg::icl_flag_next(evt21, set21, ack21);
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			evt12 <= icl_pkg::EVT_RST;
			evt21 <= icl_pkg::EVT_RST;
		end else begin
			evt12 <= next_evt12;
			evt21 <= next_evt21;
		end
	end

	// Setting one of the low four flags also latches an interrupt cause remotely.
	always_comb begin
		sts1_w      = icl_pkg::icl_flag_next({28'h0000000, sts1}, set21 & 32'h0000_000f, clr1);
		sts2_w      = icl_pkg::icl_flag_next({28'h0000000, sts2}, set12 & 32'h0000_000f, clr2);
		next_sts1   = sts1_w[icl_pkg::IRQ_EVT_W-1:0];
		next_sts2   = sts2_w[icl_pkg::IRQ_EVT_W-1:0];
		next_msk1   = (c1_wr && (c1_sel == icl_pkg::SEL_IRQ_MSK)) ? c1_wdata[3:0] : msk1;
		next_msk2   = (c2_wr && (c2_sel == icl_pkg::SEL_IRQ_MSK)) ? c2_wdata[3:0] : msk2;
		next_c1_irq = |(sts1 & msk1);
		next_c2_irq = |(sts2 & msk2);
	end

	// The interrupt lines are registered so each reaches its core from a flip-flop.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sts1   <= icl_pkg::IRQ_RST;
			sts2   <= icl_pkg::IRQ_RST;
			msk1   <= icl_pkg::IRQ_RST;
			msk2   <= icl_pkg::IRQ_RST;
			c1_irq <= 1'b0;
			c2_irq <= 1'b0;
		end else begin
			sts1   <= next_sts1;
			sts2   <= next_sts2;
			msk1   <= next_msk1;
			msk2   <= next_msk2;
			c1_irq <= next_c1_irq;
			c2_irq <= next_c2_irq;
		end
	end

	// Command registers hold any value software puts there.
	// First core's writes: its three send commands and its reply to the second core.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			next_cmd12[i] = cmd12[i];
		end
		next_rep21 = rep21;
		if (c1_wr) begin
			case (c1_sel)
				icl_pkg::SEL_TX_CMD0: next_cmd12[0] = c1_wdata;
				icl_pkg::SEL_TX_CMD1: next_cmd12[1] = c1_wdata;
				icl_pkg::SEL_TX_CMD2: next_cmd12[2] = c1_wdata;
				icl_pkg::SEL_RX_REPL: next_rep21    = c1_wdata;
				default:              next_rep21    = rep21;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 3; i++) begin
				cmd12[i] <= icl_pkg::CMD_RST;
			end
			rep21 <= icl_pkg::CMD_RST;
		end else begin
			for (int i = 0; i < 3; i++) begin
				cmd12[i] <= next_cmd12[i];
			end
			rep21 <= next_rep21;
		end
	end

	// Second core's writes: its three send commands and its reply to the first core.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			next_cmd21[i] = cmd21[i];
		end
		next_rep12 = rep12;
		if (c2_wr) begin
			case (c2_sel)
				icl_pkg::SEL_TX_CMD0: next_cmd21[0] = c2_wdata;
				icl_pkg::SEL_TX_CMD1: next_cmd21[1] = c2_wdata;
				icl_pkg::SEL_TX_CMD2: next_cmd21[2] = c2_wdata;
				icl_pkg::SEL_RX_REPL: next_rep12    = c2_wdata;
				default:              next_rep12    = rep12;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 3; i++) begin
				cmd21[i] <= icl_pkg::CMD_RST;
			end
			rep12 <= icl_pkg::CMD_RST;
		end else begin
			for (int i = 0; i < 3; i++) begin
				cmd21[i] <= next_cmd21[i];
			end
			rep12 <= next_rep12;
		end
	end

	// Read paths have no side effects, so one core never disturbs the other.
	// The own send memory and the acknowledge word are write-only and read as zero.
	always_comb begin
		case (c1_sel)
			icl_pkg::SEL_TXRAM:   c1_rdata = icl_pkg::RD_ZERO;
			icl_pkg::SEL_RXRAM:   c1_rdata = {16'h0000, ram21_q};
			icl_pkg::SEL_EVT_SET: c1_rdata = evt12;
			icl_pkg::SEL_EVT_FLG: c1_rdata = evt21;
			icl_pkg::SEL_EVT_ACK: c1_rdata = icl_pkg::RD_ZERO;
			icl_pkg::SEL_IRQ_STS: c1_rdata = {28'h0000000, sts1};
			icl_pkg::SEL_IRQ_MSK: c1_rdata = {28'h0000000, msk1};
			icl_pkg::SEL_TX_CMD0: c1_rdata = cmd12[0];
			icl_pkg::SEL_TX_CMD1: c1_rdata = cmd12[1];
			icl_pkg::SEL_TX_CMD2: c1_rdata = cmd12[2];
			icl_pkg::SEL_TX_REPL: c1_rdata = rep12;
			icl_pkg::SEL_RX_CMD0: c1_rdata = cmd21[0];
			icl_pkg::SEL_RX_CMD1: c1_rdata = cmd21[1];
			icl_pkg::SEL_RX_CMD2: c1_rdata = cmd21[2];
			icl_pkg::SEL_RX_REPL: c1_rdata = rep21;
			default:              c1_rdata = icl_pkg::RD_ZERO;
		endcase
	end

	// The second core's view mirrors the first core's with the directions swapped.
	always_comb begin
		case (c2_sel)
			icl_pkg::SEL_TXRAM:   c2_rdata = icl_pkg::RD_ZERO;
			icl_pkg::SEL_RXRAM:   c2_rdata = {16'h0000, ram12_q};
			icl_pkg::SEL_EVT_SET: c2_rdata = evt21;
			icl_pkg::SEL_EVT_FLG: c2_rdata = evt12;
			icl_pkg::SEL_EVT_ACK: c2_rdata = icl_pkg::RD_ZERO;
			icl_pkg::SEL_IRQ_STS: c2_rdata = {28'h0000000, sts2};
			icl_pkg::SEL_IRQ_MSK: c2_rdata = {28'h0000000, msk2};
			icl_pkg::SEL_TX_CMD0: c2_rdata = cmd21[0];
			icl_pkg::SEL_TX_CMD1: c2_rdata = cmd21[1];
			icl_pkg::SEL_TX_CMD2: c2_rdata = cmd21[2];
			icl_pkg::SEL_TX_REPL: c2_rdata = rep21;
			icl_pkg::SEL_RX_CMD0: c2_rdata = cmd12[0];
			icl_pkg::SEL_RX_CMD1: c2_rdata = cmd12[1];
			icl_pkg::SEL_RX_CMD2: c2_rdata = cmd12[2];
			icl_pkg::SEL_RX_REPL: c2_rdata = rep12;
			default:              c2_rdata = icl_pkg::RD_ZERO;
		endcase
	end

endmodule // icl_top

// >>> bench/icl_top_assertions.sv
// Checker for the bus timing and interrupt outputs of the inter-core link.
`timescale 1ns/10ps
module icl_top_chk (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        c1_hsel,
	input wire logic [1:0]  c1_htrans,
	input wire logic        c1_hwrite,
	input wire logic        c1_hready,
	input wire logic        c1_hreadyout,
	input wire logic [31:0] c1_hrdata,
	input wire logic        c1_hresp,
	input wire logic        c1_irq,
	input wire logic        c2_hsel,
	input wire logic [1:0]  c2_htrans,
	input wire logic        c2_hwrite,
	input wire logic        c2_hready,
	input wire logic        c2_hreadyout,
	input wire logic [31:0] c2_hrdata,
	input wire logic        c2_hresp,
	input wire logic        c2_irq
);
	logic c1_tk;
	logic c2_tk;
	logic c1_wdp;
	logic c2_wdp;
	assign c1_tk = c1_hsel & c1_htrans[1] & c1_hready;
	assign c2_tk = c2_hsel & c2_htrans[1] & c2_hready;
	// Marks the data phase of a write on each port.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			c1_wdp <= 1'b0;
			c2_wdp <= 1'b0;
		end else begin
			c1_wdp <= c1_tk & c1_hwrite;
			c2_wdp <= c2_tk & c2_hwrite;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence c1_wait_s; !c1_hreadyout ##1 c1_hreadyout; endsequence
	sequence c2_wait_s; !c2_hreadyout ##1 c2_hreadyout; endsequence
	bus_okay_a: assert property (c1_hresp == icl_pkg::HRESP_OKAY && c2_hresp == icl_pkg::HRESP_OKAY)
		else $error("response not OKAY");
	c1_rd_wait_a: assert property (c1_tk && !c1_hwrite |=> c1_wait_s)
		else $error("first core read wait wrong");
	c2_rd_wait_a: assert property (c2_tk && !c2_hwrite |=> c2_wait_s)
		else $error("second core read wait wrong");
	c1_wr_fast_a: assert property (c1_tk && c1_hwrite |=> c1_hreadyout)
		else $error("first core write stalled");
	c2_wr_fast_a: assert property (c2_tk && c2_hwrite |=> c2_hreadyout)
		else $error("second core write stalled");
	rdata_hold_a: assert property (!$past(c1_tk && !c1_hwrite, 2) |-> $stable(c1_hrdata))
		else $error("read data changed without a read");
	c1_irq_rise_a: assert property ($rose(c1_irq) |-> $past(c1_wdp || c2_wdp, 2))
		else $error("first core irq rose without a write");
	c2_irq_rise_a: assert property ($rose(c2_irq) |-> $past(c1_wdp || c2_wdp, 2))
		else $error("second core irq rose without a write");
	c1_irq_fall_a: assert property ($fell(c1_irq) |-> $past(c1_wdp, 2))
		else $error("first core irq fell without own write");
	c2_irq_fall_a: assert property ($fell(c2_irq) |-> $past(c2_wdp, 2))
		else $error("second core irq fell without own write");
endmodule // icl_top_chk
bind icl_top icl_top_chk chk (.clock(clock), .rst_b(rst_b), .c1_hsel(c1_hsel), .c1_htrans(c1_htrans),
	.c1_hwrite(c1_hwrite), .c1_hready(c1_hready), .c1_hreadyout(c1_hreadyout), .c1_hrdata(c1_hrdata),
	.c1_hresp(c1_hresp), .c1_irq(c1_irq), .c2_hsel(c2_hsel), .c2_htrans(c2_htrans), .c2_hwrite(c2_hwrite),
	.c2_hready(c2_hready), .c2_hreadyout(c2_hreadyout), .c2_hrdata(c2_hrdata), .c2_hresp(c2_hresp),
	.c2_irq(c2_irq));

// >>> bench/icl_core_model.sv
// Bus master model of one processor core on its link port.
`timescale 1ns/10ps
module icl_core_model (
	input  wire logic        clock,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [13:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	assign hsize = 3'h2;
	initial begin
		hsel = 1'b0;
		haddr = 14'h0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
	end
	// Write data is inverted during the address phase so stale data never looks valid.
	task automatic xfer(input logic wr, input logic [13:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= icl_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= a;
		hwdata <= ~hwdata;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule // icl_core_model

// >>> bench/test_dual_core_message_exchange.sv
// Self-checking bench for the inter-core link with both cores as bus masters.
`timescale 1ns/10ps
module test_dual_core_message_exchange;
	logic        clock;
	logic        rst_b;
	logic        c1_hsel, c2_hsel, c1_hwrite, c2_hwrite, c1_hreadyout, c2_hreadyout;
	logic        c1_hresp, c2_hresp, c1_irq, c2_irq;
	logic [13:0] c1_haddr, c2_haddr;
	logic [1:0]  c1_htrans, c2_htrans;
	logic [2:0]  c1_hsize, c2_hsize;
	logic [31:0] c1_hwdata, c2_hwdata, c1_hrdata, c2_hrdata;
	int          fail_count, checks, cycles;
	icl_top dut (.clock(clock), .rst_b(rst_b),
		.c1_hsel(c1_hsel), .c1_haddr(c1_haddr), .c1_htrans(c1_htrans), .c1_hwrite(c1_hwrite), .c1_hsize(c1_hsize),
		.c1_hwdata(c1_hwdata), .c1_hready(c1_hreadyout), .c1_hreadyout(c1_hreadyout), .c1_hrdata(c1_hrdata),
		.c1_hresp(c1_hresp), .c1_irq(c1_irq),
		.c2_hsel(c2_hsel), .c2_haddr(c2_haddr), .c2_htrans(c2_htrans), .c2_hwrite(c2_hwrite), .c2_hsize(c2_hsize),
		.c2_hwdata(c2_hwdata), .c2_hready(c2_hreadyout), .c2_hreadyout(c2_hreadyout), .c2_hrdata(c2_hrdata),
		.c2_hresp(c2_hresp), .c2_irq(c2_irq));
	icl_core_model first (.clock(clock), .hready(c1_hreadyout), .hrdata(c1_hrdata), .hsel(c1_hsel),
		.haddr(c1_haddr), .htrans(c1_htrans), .hwrite(c1_hwrite), .hsize(c1_hsize), .hwdata(c1_hwdata));
	icl_core_model second (.clock(clock), .hready(c2_hreadyout), .hrdata(c2_hrdata), .hsel(c2_hsel),
		.haddr(c2_haddr), .htrans(c2_htrans), .hwrite(c2_hwrite), .hsize(c2_hsize), .hwdata(c2_hwdata));
	always #2.5 clock = ~clock;
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input int c, input logic w, input logic [13:0] a, input logic [31:0] d, output logic [31:0] q);
		if (c == 1) first.xfer(w, a, d, q);
		else second.xfer(w, a, d, q);
	endtask
	task automatic wr(input int c, input logic [13:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(c, 1'b1, a, d, q);
	endtask
	task automatic rd_chk(input int c, input logic [13:0] a, input logic [31:0] e, input string n);
		logic [31:0] q;
		bus(c, 1'b0, a, 32'h0, q);
		chk(n, e, q);
	endtask
	task automatic s_ram();
		for (int c = 1; c <= 2; c++) begin
			wr(c, 14'h0000, 32'hdead_1234 + c);
			wr(c, 14'h0ffc, 32'h0000_5a5a + c);
			wr(3 - c, 14'h1000, 32'hffff_ffff);
			rd_chk(3 - c, 14'h1000, 32'h0000_1234 + c, "recv ram first word");
			rd_chk(3 - c, 14'h1ffc, 32'h0000_5a5a + c, "recv ram last word");
			rd_chk(c, 14'h0000, 32'h0, "own send ram");
		end
		rd_chk(2, 14'h1000, 32'h0000_1235, "ram direction kept");
	endtask
	task automatic s_evt();
		for (int c = 1; c <= 2; c++) begin
			wr(c, icl_pkg::EVT_SET_OFS, 32'h8000_0010);
			rd_chk(3 - c, icl_pkg::EVT_FLG_OFS, 32'h8000_0010, "incoming flags");
			rd_chk(c, icl_pkg::EVT_FLG_OFS, 32'h0, "own incoming flags");
			rd_chk(3 - c, icl_pkg::IRQ_STS_OFS, 32'h0, "poll only status");
			wr(3 - c, icl_pkg::EVT_ACK_OFS, 32'h8000_0000);
			rd_chk(c, icl_pkg::EVT_SET_OFS, 32'h0000_0010, "pending flags");
			rd_chk(3 - c, icl_pkg::EVT_FLG_OFS, 32'h0000_0010, "flags after ack");
			wr(3 - c, icl_pkg::EVT_ACK_OFS, 32'h0000_0010);
			rd_chk(c, icl_pkg::EVT_SET_OFS, 32'h0, "flags cleared");
		end
	endtask
	task automatic s_irq();
		for (int c = 1; c <= 2; c++) begin
			wr(3 - c, icl_pkg::IRQ_MSK_OFS, 32'h0000_0008);
			rd_chk(3 - c, icl_pkg::IRQ_MSK_OFS, 32'h0000_0008, "mask");
			wr(c, icl_pkg::EVT_SET_OFS, 32'h0000_000c);
			@(posedge clock);
			#1;
			chk("irq raised", 32'h1, {31'h0, (c == 1) ? c2_irq : c1_irq});
			rd_chk(3 - c, icl_pkg::IRQ_STS_OFS, 32'h0000_000c, "status");
			wr(3 - c, icl_pkg::IRQ_STS_OFS, 32'h0000_0008);
			@(posedge clock);
			#1;
			chk("irq cleared", 32'h0, {31'h0, (c == 1) ? c2_irq : c1_irq});
			rd_chk(3 - c, icl_pkg::IRQ_STS_OFS, 32'h0000_0004, "status masked bit");
			wr(3 - c, icl_pkg::IRQ_STS_OFS, 32'h0000_0004);
			wr(3 - c, icl_pkg::EVT_ACK_OFS, 32'h0000_000c);
			wr(3 - c, icl_pkg::IRQ_MSK_OFS, 32'h0);
		end
	endtask
	task automatic s_cmd();
		for (int c = 1; c <= 2; c++) begin
			rd_chk(3 - c, icl_pkg::RX_CMD0_OFS, 32'h0, "command reset");
			wr(c, icl_pkg::TX_CMD0_OFS, 32'hffff_ffff);
			wr(c, icl_pkg::TX_CMD1_OFS, 32'h0000_0001);
			wr(c, icl_pkg::TX_CMD2_OFS, 32'h8000_0000 + c);
			wr(3 - c, icl_pkg::RX_CMD1_OFS, 32'h0);
			wr(c, icl_pkg::TX_REPL_OFS, 32'h0000_0001);
			wr(3 - c, icl_pkg::RX_REPL_OFS, 32'h0bad_0000 + c);
			rd_chk(3 - c, icl_pkg::RX_CMD0_OFS, 32'hffff_ffff, "command word 0");
			rd_chk(3 - c, icl_pkg::RX_CMD1_OFS, 32'h0000_0001, "command word 1");
			rd_chk(3 - c, icl_pkg::RX_CMD2_OFS, 32'h8000_0000 + c, "command word 2");
			rd_chk(c, icl_pkg::TX_REPL_OFS, 32'h0bad_0000 + c, "reply word");
			rd_chk(c, icl_pkg::TX_CMD1_OFS, 32'h0000_0001, "own command readback");
		end
	endtask
	task automatic s_misc();
		wr(1, 14'h2034, 32'hffff_ffff);
		rd_chk(1, 14'h2034, 32'h0, "unmapped read");
		fork
			wr(1, icl_pkg::TX_CMD0_OFS, 32'h1111_1111);
			wr(2, icl_pkg::RX_REPL_OFS, 32'h2222_2222);
		join
		fork
			wr(1, icl_pkg::EVT_SET_OFS, 32'h0000_0100);
			wr(2, 14'h0010, 32'h0000_7777);
		join
		rd_chk(2, icl_pkg::RX_CMD0_OFS, 32'h1111_1111, "parallel command");
		rd_chk(1, icl_pkg::TX_REPL_OFS, 32'h2222_2222, "parallel reply");
		rd_chk(2, icl_pkg::EVT_FLG_OFS, 32'h0000_0100, "parallel flag");
		rd_chk(1, 14'h1010, 32'h0000_7777, "parallel ram");
	endtask
	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		s_ram();
		s_evt();
		s_irq();
		s_cmd();
		s_misc();
		report_and_stop();
	end
endmodule // test_dual_core_message_exchange
